// ===== design/flash_seq_pkg.sv
// constants and types for the flash fetch, wait and abort sequencer
package flash_seq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int PAGE_BYTES = 512;
    localparam int ERASE_MS = 20;
    localparam int WRITE_US = 50;
    localparam int ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
    localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
    localparam int ABORT_CYCLES = 10;
    localparam int FETCH_XTRA_WIDE = 2;
    localparam int FETCH_XTRA_NARROW = 1;
    localparam int BRANCH_DECODE = 1;
    localparam int PIPE_FILL = 4;
    localparam int DP_DECODE = 1;
    localparam int DP_ASSEMBLE = 2;
    localparam int DP_TAIL = 1;
    localparam int DEAD_SINGLE = 1;
    localparam int WORD_ACCESS = 2;
    localparam int HALF_ACCESS = 1;
    localparam int MULTI_MAX = 16;
    localparam int CNT_W = 32;

    // request kinds issued by the core
    typedef enum logic [3:0] {
        REQ_FETCH = 4'h0,
        REQ_BRANCH = 4'h1,
        REQ_DP_REG = 4'h2,
        REQ_DP_FLASH = 4'h3,
        REQ_LD_WORD = 4'h4,
        REQ_LD_HALF = 4'h5,
        REQ_LD_MULTI = 4'h6,
        REQ_ST_WORD = 4'h7,
        REQ_ST_HALF = 4'h8,
        REQ_ST_MULTI = 4'h9,
        REQ_ERASE = 4'hA
    } req_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_PROG = 2'b10,
        ST_ABORT = 2'b11
    } seq_state_t;
endpackage

// ===== design/flash_fetch_wait_and_abort.sv
// flash access sequencer: fetch and data wait cycles, erase/write stall and abort
//
// Notes on behaviour
// - 16-bit array: flash fetch slower than one cycle at divider zero; data needs dead time
// - wide instruction mode at divider zero: fetch adds two cycles
// - narrow instruction mode: fetch adds one cycle
// - control flow from flash: one decode cycle then four pipeline refill cycles
// - register-only data op adds nothing; flash data adds decode, two assemble, one tail
// - single transfers: 2/1 fetch, one dead cycle, word 2 / half 1 access or writes
// - multiple of N words: N dead cycles, 2N accesses or 2N word programming times
// - execution from flash stalls for the whole erase or write
// - page erase of 512 bytes holds the flash for 20 ms
// - one 16-bit word write holds the flash for 50 us
// - enabled interrupt during erase or write aborts it and frees the core
// - abort completes in ten core clock cycles
// - SRAM fetch is single cycle, the baseline for flash counts
`timescale 1ns/1ps
`default_nettype none
module flash_fetch_wait_and_abort
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int WRITE_CNT = WRITE_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // core request
    input wire logic req_valid,
    input wire req_kind_t req_kind,
    input wire logic req_in_flash,
    input wire logic [4:0] req_count,
    input wire logic wide_mode,
    input wire logic [2:0] core_clock_divider_setting,
    input wire logic irq_enabled,
    // answer to core
    output logic core_wait,
    output logic data_valid,
    output logic prog_busy,
    output logic prog_aborted
);

////////////////////////////////////////////////////////////////////////////////
// cycle cost of one request

    function automatic logic [CNT_W-1:0] fetch_xtra(input logic wide,
                                                   input logic [2:0] div);
        logic [CNT_W-1:0] r;
        r = '0;
        if (wide && div == 3'h0) begin
            r = CNT_W'(FETCH_XTRA_WIDE);
        end else if (!wide) begin
            r = CNT_W'(FETCH_XTRA_NARROW);
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] cost(input req_kind_t k, input logic fl,
                                              input logic [4:0] n, input logic wide,
                                              input logic [2:0] div);
        logic [CNT_W-1:0] f;
        logic [CNT_W-1:0] nn;
        logic [CNT_W-1:0] r;
        f = fetch_xtra(wide, div);
        nn = CNT_W'(n);
        r = '0;
        unique case (k)
            REQ_FETCH: r = fl ? f : '0;
            REQ_BRANCH: r = fl ? CNT_W'(BRANCH_DECODE + PIPE_FILL) : '0;
            REQ_DP_REG: r = '0;
            REQ_DP_FLASH: r = CNT_W'(DP_DECODE + DP_ASSEMBLE + DP_TAIL);
            REQ_LD_WORD: r = f + CNT_W'(DEAD_SINGLE + WORD_ACCESS);
            REQ_LD_HALF: r = f + CNT_W'(DEAD_SINGLE + HALF_ACCESS);
            REQ_LD_MULTI: r = f + nn + CNT_W'(WORD_ACCESS) * nn;
            REQ_ST_WORD, REQ_ST_HALF, REQ_ST_MULTI: r = f + (k == REQ_ST_MULTI ? nn
                                                    : CNT_W'(DEAD_SINGLE));
            REQ_ERASE: r = '0;
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] prog_words(input req_kind_t k,
                                                    input logic [4:0] n);
        logic [CNT_W-1:0] r;
        r = '0;
        if (k == REQ_ST_WORD) begin
            r = CNT_W'(WORD_ACCESS);
        end else if (k == REQ_ST_HALF) begin
            r = CNT_W'(HALF_ACCESS);
        end else if (k == REQ_ST_MULTI) begin
            r = CNT_W'(WORD_ACCESS) * CNT_W'(n);
        end
        return r;
    endfunction

////////////////////////////////////////////////////////////////////////////////
// sequencer

    seq_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] words_q;
    logic [CNT_W-1:0] c_now;
    logic is_erase;

    assign c_now = cost(req_kind, req_in_flash, req_count, wide_mode,
                        core_clock_divider_setting);
    assign is_erase = req_kind == REQ_ERASE;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            words_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: if (req_valid) begin
                    words_q <= prog_words(req_kind, req_count);
                    if (is_erase) begin
                        state_q <= ST_PROG;
                        cnt_q <= CNT_W'(ERASE_CNT - 1);
                    end else if (c_now != '0) begin
                        state_q <= ST_WAIT;
                        cnt_q <= c_now - CNT_W'(1);
                    end
                end
                ST_WAIT: if (cnt_q == '0) begin
                    if (words_q != '0) begin
                        state_q <= ST_PROG;
                        cnt_q <= CNT_W'(WRITE_CNT - 1);
                        words_q <= words_q - CNT_W'(1);
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
                ST_PROG: if (irq_enabled) begin
                    state_q <= ST_ABORT;
                    cnt_q <= CNT_W'(ABORT_CYCLES - 1);
                    words_q <= '0;
                end else if (cnt_q == '0) begin
                    if (words_q != '0) begin
                        cnt_q <= CNT_W'(WRITE_CNT - 1);
                        words_q <= words_q - CNT_W'(1);
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
                ST_ABORT: if (cnt_q == '0) begin
                    state_q <= ST_IDLE;
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// outputs to the core

    logic done_d;
    logic wait_d;
    assign done_d = (state_q == ST_IDLE && req_valid && !is_erase && c_now == '0)
                    || (state_q == ST_WAIT && cnt_q == '0 && words_q == '0)
                    || (state_q == ST_PROG && !irq_enabled && cnt_q == '0
                        && words_q == '0)
                    || (state_q == ST_ABORT && cnt_q == '0);
    assign wait_d = !done_d && (state_q != ST_IDLE
                    || (req_valid && (is_erase || c_now != '0)));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_wait <= 1'b0;
            data_valid <= 1'b0;
        end else begin
            core_wait <= wait_d;
            data_valid <= done_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prog_busy <= 1'b0;
            prog_aborted <= 1'b0;
        end else begin
            prog_busy <= state_q == ST_PROG && !(irq_enabled || (cnt_q == '0
                         && words_q == '0));
            prog_aborted <= state_q == ST_PROG && irq_enabled;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// checks

    AST_ABORT_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_PROG && irq_enabled |=> (state_q == ST_ABORT
        && cnt_q == CNT_W'(ABORT_CYCLES - 1)) ##9 (state_q == ST_ABORT && cnt_q == '0)
        ##1 (state_q == ST_IDLE)) else $error("abort length wrong");
    AST_NARROW_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_FETCH && req_in_flash
        && !wide_mode |=> core_wait ##1 data_valid && !core_wait)
        else $error("narrow fetch timing wrong");
    AST_WIDE_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_FETCH && req_in_flash
        && wide_mode && core_clock_divider_setting == 3'h0
        |=> core_wait [*2] ##1 data_valid) else $error("wide fetch timing wrong");
    AST_SRAM_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_FETCH && !req_in_flash
        |=> data_valid && !core_wait) else $error("sram fetch not single cycle");
    AST_BRANCH: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_BRANCH && req_in_flash
        |=> core_wait [*5] ##1 data_valid) else $error("branch refill wrong");
    AST_DP_REG: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_DP_REG
        |=> data_valid) else $error("register op stalled");
    AST_DP_FLASH: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_DP_FLASH
        |=> core_wait [*4] ##1 data_valid) else $error("flash data op timing wrong");
    AST_HALF_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_LD_HALF && !wide_mode
        |=> core_wait [*3] ##1 data_valid) else $error("half load timing wrong");
    AST_STALL: assert property (@(posedge mclk) disable iff (!rst_n)
        prog_busy |-> core_wait) else $error("core not stalled during program");
    AST_VALID_NO_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
        data_valid |-> !core_wait) else $error("wait held with data valid");
    AST_ERASE_START: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_ERASE
        |=> state_q == ST_PROG && cnt_q == CNT_W'(ERASE_CNT - 1))
        else $error("erase count wrong");
    AST_WRITE_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_WAIT && cnt_q == '0 && words_q != '0
        |=> state_q == ST_PROG && cnt_q == CNT_W'(WRITE_CNT - 1))
        else $error("write count wrong");

    COV_ABORT: cover property (@(posedge mclk) disable iff (!rst_n) prog_aborted);
    COV_ERASE_DONE: cover property (@(posedge mclk) disable iff (!rst_n)
        prog_busy ##1 !prog_busy && data_valid);
    COV_MULTI: cover property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_LD_MULTI);
    COV_BRANCH: cover property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && req_valid && req_kind == REQ_BRANCH && req_in_flash);

endmodule
`default_nettype wire

// ===== sim/core_model.sv
// core-side request model for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module core_model
    import flash_seq_pkg::*;
(
    // clock
    input wire logic mclk,
    // requests
    output logic req_valid,
    output var req_kind_t req_kind,
    output logic req_in_flash,
    output logic [4:0] req_count,
    output logic wide_mode,
    output logic [2:0] core_clock_divider_setting,
    output logic irq_enabled,
    // answers
    input wire logic core_wait,
    input wire logic data_valid,
    input wire logic prog_busy,
    input wire logic prog_aborted
);
    int waits;
    int ab_waits;
    int ab_seen;
    int busy_seen;
    logic wait_at_dv;

    initial begin
        req_valid = 1'b0;
        req_kind = REQ_FETCH;
        req_in_flash = 1'b0;
        req_count = 5'h00;
        wide_mode = 1'b0;
        core_clock_divider_setting = 3'h0;
        irq_enabled = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one request, counting stall cycles until data is valid
    task automatic run(input req_kind_t k, input logic fl, input logic [4:0] n,
                       input logic wd, input logic [2:0] dv, input int irq_at);
        int t;
        t = 0;
        waits = 0;
        ab_waits = 0;
        ab_seen = 0;
        busy_seen = 0;
        wait_at_dv = 1'b1;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_in_flash <= fl;
        req_count <= n;
        wide_mode <= wd;
        core_clock_divider_setting <= dv;
        irq_enabled <= 1'b0;
        @(posedge mclk);
        req_valid <= 1'b0;
        while (t < 3000) begin
            #1;
            if (prog_busy === 1'b1) busy_seen = 1;
            if (prog_aborted === 1'b1) ab_seen = 1;
            if (ab_seen == 1 && core_wait === 1'b1) ab_waits++;
            if (data_valid === 1'b1) begin
                wait_at_dv = core_wait;
                break;
            end
            if (core_wait === 1'b1 && ab_seen == 0) waits++;
            @(posedge mclk);
            t++;
            irq_enabled <= irq_at > 0 && t >= irq_at && ab_seen == 0;
        end
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_seq_pkg::*;
    localparam int ER = 20;
    localparam int WR = 5;
    logic mclk;
    logic rst_n;
    logic req_valid;
    req_kind_t req_kind;
    logic req_in_flash;
    logic [4:0] req_count;
    logic wide_mode;
    logic [2:0] core_clock_divider_setting;
    logic irq_enabled;
    logic core_wait;
    logic data_valid;
    logic prog_busy;
    logic prog_aborted;
    int fails = 0;
    int n_checks = 0;

`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %0d seen %0d", w, e, g); end end

    flash_fetch_wait_and_abort #(.ERASE_CNT(ER), .WRITE_CNT(WR)) flash_fetch_wait_and_abort_i (
        .mclk, .rst_n, .req_valid, .req_kind, .req_in_flash, .req_count, .wide_mode,
        .core_clock_divider_setting, .irq_enabled, .core_wait, .data_valid, .prog_busy,
        .prog_aborted);
    core_model core_model_i (
        .mclk, .req_valid, .req_kind, .req_in_flash, .req_count, .wide_mode,
        .core_clock_divider_setting, .irq_enabled, .core_wait, .data_valid, .prog_busy,
        .prog_aborted);

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    function automatic int fx(input logic wd, input logic [2:0] dv);
        return wd ? (dv == 3'h0 ? 2 : 0) : 1;
    endfunction

    task automatic op(input req_kind_t k, input logic [4:0] n, input logic wd,
                      input logic [2:0] dv, input int exp);
        core_model_i.run(k, 1'b1, n, wd, dv, 0);
        `CHK("wait cycles", exp, core_model_i.waits)
        `CHK("wait at valid", 1'b0, core_model_i.wait_at_dv)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_fetch();
        op(REQ_FETCH, 5'h00, 1'b1, 3'h0, 2);
        op(REQ_FETCH, 5'h00, 1'b1, 3'h3, 0);
        op(REQ_FETCH, 5'h00, 1'b0, 3'h0, 1);
        op(REQ_FETCH, 5'h00, 1'b0, 3'h5, 1);
        core_model_i.run(REQ_FETCH, 1'b0, 5'h00, 1'b1, 3'h0, 0);
        `CHK("sram fetch", 0, core_model_i.waits)
    endtask

    task automatic t_flow();
        op(REQ_BRANCH, 5'h00, 1'b0, 3'h2, 5);
        op(REQ_DP_REG, 5'h00, 1'b1, 3'h0, 0);
        op(REQ_DP_FLASH, 5'h00, 1'b1, 3'h0, 4);
    endtask

    task automatic t_load();
        op(REQ_LD_WORD, 5'h00, 1'b1, 3'h0, fx(1'b1, 3'h0) + 3);
        op(REQ_LD_WORD, 5'h00, 1'b1, 3'h3, fx(1'b1, 3'h3) + 3);
        op(REQ_LD_HALF, 5'h00, 1'b0, 3'h0, fx(1'b0, 3'h0) + 2);
        op(REQ_LD_MULTI, 5'h02, 1'b0, 3'h1, fx(1'b0, 3'h1) + 6);
        op(REQ_LD_MULTI, 5'h10, 1'b1, 3'h0, fx(1'b1, 3'h0) + 48);
    endtask

    task automatic t_store();
        op(REQ_ST_WORD, 5'h00, 1'b0, 3'h0, fx(1'b0, 3'h0) + 1 + 2 * WR);
        `CHK("busy in write", 1, core_model_i.busy_seen)
        op(REQ_ST_HALF, 5'h00, 1'b1, 3'h0, fx(1'b1, 3'h0) + 1 + WR);
        op(REQ_ST_MULTI, 5'h02, 1'b0, 3'h0, fx(1'b0, 3'h0) + 2 + 4 * WR);
    endtask

    task automatic t_erase();
        op(REQ_ERASE, 5'h00, 1'b1, 3'h0, ER);
        `CHK("busy in erase", 1, core_model_i.busy_seen)
    endtask

    task automatic t_abort();
        core_model_i.run(REQ_ERASE, 1'b1, 5'h00, 1'b1, 3'h0, 6);
        `CHK("abort pulse", 1, core_model_i.ab_seen)
        `CHK("abort waits", ABORT_CYCLES, core_model_i.ab_waits)
        op(REQ_ERASE, 5'h00, 1'b1, 3'h0, ER);
        core_model_i.run(REQ_LD_WORD, 1'b1, 5'h00, 1'b1, 3'h0, 1);
        `CHK("irq outside prog", 0, core_model_i.ab_seen)
        `CHK("load with irq", 5, core_model_i.waits)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, sequence and verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("idle outputs", 4'h0, {core_wait, data_valid, prog_busy, prog_aborted})
        t_fetch();
        t_flow();
        t_load();
        t_store();
        t_erase();
        t_abort();
        wrap_up();
    end

    initial begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
